// [common/phy_irq_pkg.sv]
// constants and types of the phy interrupt status and enable register
// assumes an apb slave on a single 250 mhz clock with async low reset
// What this block does
// RULE1: an auto-negotiation completion sets status bit 10 until cleared.
// RULE2: false-carrier counter passing half its range sets status bit 9.
// RULE3: receive-error counter passing half its range sets status bit 8.
// RULE4: a read/write link quality change enable bit resets to zero.
// RULE5: a read/write energy detect change enable bit resets to zero.
// RULE6: a read/write speed change enable bit resets to zero.
// RULE7: a read/write duplex change enable bit resets to zero.
// RULE8: a read/write negotiation complete enable bit resets to zero.
// RULE9: a read/write false-carrier half-full enable bit resets to zero.
// RULE10: a read/write receive-error half-full enable bit resets to zero.
// RULE11: a change of resolved duplex mode sets status bit 11.
// RULE12: a read clears the pending bits it returned; new events set again.
// RULE13: the interrupt is high while a pending bit and its enable are set.
package phy_irq_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FIELD_W = 8;
  localparam int CNT_W = 8;

  // register byte address
  localparam logic [ADDR_W-1:0] ISE1_ADDR = 12'h000;
  localparam int WORD_LSB = 2;

  // field placement inside the register
  localparam int STAT_LSB = 8;
  localparam int EN_LSB = 0;
  localparam int REG_W = 16;

  // bit positions within an 8-bit field (status bit = pos + STAT_LSB)
  localparam int POS_LQ = 7;
  localparam int POS_ENERGY = 6;
  localparam int POS_LINK = 5;
  localparam int POS_SPEED = 4;
  localparam int POS_DUPLEX = 3;
  localparam int POS_AN = 2;
  localparam int POS_FC = 1;
  localparam int POS_RXERR = 0;

  // reset values
  localparam logic [FIELD_W-1:0] STAT_RST = 8'h00;
  localparam logic [FIELD_W-1:0] EN_RST = 8'h00;

  // live phy status levels whose changes are events
  typedef struct packed {
    logic link_quality;
    logic energy_detect;
    logic link_up;
    logic speed_100;
    logic full_duplex;
  } phy_level_t;

  localparam int LEVEL_W = $bits(phy_level_t);

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W/8-1:0] pstrb;
  } apb_req_t;

endpackage : phy_irq_pkg

// [hdl/level_change_detect.sv]
// flags any change of a group of status levels as one-cycle pulses
// assumes the levels are synchronous to clk
`timescale 1ns/1ps
module level_change_detect #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] level,
  output logic [W-1:0] changed
);

  logic [W-1:0] last_q;
  logic primed_q;

  // no change reported until a first sample is held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q <= '0;
      primed_q <= 1'b0;
    end
    else
    begin
      last_q <= level;
      primed_q <= 1'b1;
    end
  end

  assign changed = primed_q ? (level ^ last_q) : '0;

endmodule : level_change_detect

// [hdl/halffull_detect.sv]
// pulses once when an event counter rises beyond half of its range
// assumes the counter value is synchronous to clk
`timescale 1ns/1ps
module halffull_detect #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CNT_W-1:0] count,
  output logic crossed
);

  localparam logic [CNT_W-1:0] HALF = {1'b1, {(CNT_W-1){1'b0}}};

  logic over;
  logic over_q;

  assign over = count > HALF;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      over_q <= 1'b0;
    end
    else
    begin
      over_q <= over;
    end
  end

  assign crossed = over & ~over_q;

endmodule : halffull_detect

// [hdl/phy_irq_status_enable.sv]
// interrupt status and enable register of a 10/100 phy, apb slave
// assumes apb signals and phy inputs synchronous to clk
`timescale 1ns/1ps
module phy_irq_status_enable #(
  parameter int CNT_W = phy_irq_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [phy_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [phy_irq_pkg::DATA_W-1:0] pwdata,
  input wire logic [phy_irq_pkg::DATA_W/8-1:0] pstrb,
  output logic [phy_irq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire phy_irq_pkg::phy_level_t phy_level,
  input wire logic an_complete,
  input wire logic [CNT_W-1:0] false_carrier_event_counter,
  input wire logic [CNT_W-1:0] receive_error_event_counter,
  output logic irq
);

  localparam int FW = phy_irq_pkg::FIELD_W;
  localparam int SL = phy_irq_pkg::STAT_LSB;
  localparam int EL = phy_irq_pkg::EN_LSB;
  localparam int LW = phy_irq_pkg::LEVEL_W;

  phy_irq_pkg::apb_req_t req;
  logic [FW-1:0] stat_q;
  logic [FW-1:0] stat_d;
  logic [FW-1:0] en_q;
  logic [FW-1:0] ev_vec;
  logic [FW-1:0] clr_vec;
  logic [LW-1:0] level_chg;
  logic an_q;
  logic an_rise;
  logic fc_cross;
  logic rx_cross;
  logic [phy_irq_pkg::DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic hit;
  logic first_access;
  logic done;
  logic rd_done;
  logic wr_done;

  function automatic logic addr_hit(
    input logic [phy_irq_pkg::ADDR_W-1:0] a
  );
    addr_hit = a[phy_irq_pkg::ADDR_W-1:phy_irq_pkg::WORD_LSB] ==
      phy_irq_pkg::ISE1_ADDR[phy_irq_pkg::ADDR_W-1:phy_irq_pkg::WORD_LSB];
  endfunction : addr_hit

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
    paddr: paddr, pwdata: pwdata, pstrb: pstrb};

  // event sources
  level_change_detect #(
    .W(LW)
  ) u_level_chg (
    .clk(clk),
    .rst_n(rst_n),
    .level(phy_level),
    .changed(level_chg)
  );

  halffull_detect #(
    .CNT_W(CNT_W)
  ) u_fc_half (
    .clk(clk),
    .rst_n(rst_n),
    .count(false_carrier_event_counter),
    .crossed(fc_cross)
  );

  halffull_detect #(
    .CNT_W(CNT_W)
  ) u_rx_half (
    .clk(clk),
    .rst_n(rst_n),
    .count(receive_error_event_counter),
    .crossed(rx_cross)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      an_q <= 1'b0;
    end
    else
    begin
      an_q <= an_complete;
    end
  end

  assign an_rise = an_complete & ~an_q;

  always_comb
  begin
    ev_vec = '0;
    ev_vec[phy_irq_pkg::POS_LQ] = level_chg[4];
    ev_vec[phy_irq_pkg::POS_ENERGY] = level_chg[3];
    ev_vec[phy_irq_pkg::POS_LINK] = level_chg[2];
    ev_vec[phy_irq_pkg::POS_SPEED] = level_chg[1];
    ev_vec[phy_irq_pkg::POS_DUPLEX] = level_chg[0]; // RULE11
    ev_vec[phy_irq_pkg::POS_AN] = an_rise; // RULE1
    ev_vec[phy_irq_pkg::POS_FC] = fc_cross; // RULE2
    ev_vec[phy_irq_pkg::POS_RXERR] = rx_cross; // RULE3
  end

  // apb decode
  assign hit = addr_hit(req.paddr);
  assign first_access = req.psel & req.penable & ~pready_q;
  assign done = req.psel & req.penable & pready_q;
  assign rd_done = done & ~req.pwrite & hit;
  assign wr_done = done & req.pwrite & hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= first_access;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= first_access & ~hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= '0;
    end
    else if (first_access)
    begin
      prdata_q <= '0;
      if (hit && !req.pwrite)
      begin
        prdata_q[SL +: FW] <= stat_q;
        prdata_q[EL +: FW] <= en_q;
      end
    end
  end

  // pending bits: read clears what was returned, write one clears
  always_comb
  begin
    clr_vec = '0;
    if (rd_done)
    begin
      clr_vec = prdata_q[SL +: FW]; // RULE12
    end
    else if (wr_done && req.pstrb[SL/8])
    begin
      clr_vec = req.pwdata[SL +: FW];
    end
    stat_d = (stat_q & ~clr_vec) | ev_vec; // RULE12
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q <= phy_irq_pkg::STAT_RST;
    end
    else
    begin
      stat_q <= stat_d;
    end
  end

  // enable bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= phy_irq_pkg::EN_RST; // RULE4 RULE5 RULE6 RULE7
    end
    else if (wr_done && req.pstrb[EL/8])
    begin
      en_q <= req.pwdata[EL +: FW]; // RULE8 RULE9 RULE10
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(stat_q & en_q); // RULE13
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // checks
  property p_an_sets;
    @(posedge clk) disable iff (!rst_n)
    an_complete && !an_q |=> stat_q[phy_irq_pkg::POS_AN];
  endproperty
  a_an_sets: assert property (p_an_sets) // RULE1
    else $error("negotiation completion did not set its status bit");

  property p_fc_sets;
    @(posedge clk) disable iff (!rst_n)
    fc_cross |=> stat_q[phy_irq_pkg::POS_FC];
  endproperty
  a_fc_sets: assert property (p_fc_sets) // RULE2
    else $error("false-carrier half-full did not set its status bit");

  property p_rx_sets;
    @(posedge clk) disable iff (!rst_n)
    $rose(receive_error_event_counter > {1'b1, {(CNT_W-1){1'b0}}})
    |-> ##1 stat_q[phy_irq_pkg::POS_RXERR];
  endproperty
  a_rx_sets: assert property (p_rx_sets) // RULE3
    else $error("receive-error half-full did not set its status bit");

  property p_duplex_sets;
    @(posedge clk) disable iff (!rst_n)
    level_chg[0] |=> stat_q[phy_irq_pkg::POS_DUPLEX];
  endproperty
  a_duplex_sets: assert property (p_duplex_sets) // RULE11
    else $error("duplex change did not set its status bit");

  property p_en_write;
    @(posedge clk) disable iff (!rst_n)
    wr_done && pstrb[EL/8] |=> en_q == $past(pwdata[EL +: FW]);
  endproperty
  a_en_write: assert property (p_en_write) // RULE8
    else $error("enable bits did not take the written value");

  property p_en_hold;
    @(posedge clk) disable iff (!rst_n)
    !wr_done |=> $stable(en_q);
  endproperty
  a_en_hold: assert property (p_en_hold) // RULE9
    else $error("enable bits changed without a write");

  property p_read_clears;
    @(posedge clk) disable iff (!rst_n)
    rd_done && ev_vec == '0 |=>
      (stat_q & $past(prdata_q[SL +: FW])) == '0;
  endproperty
  a_read_clears: assert property (p_read_clears) // RULE12
    else $error("read did not clear the returned pending bits");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    ##1 irq_q == $past(|(stat_q & en_q));
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE13
    else $error("interrupt output does not follow pending and enabled");

  property p_apb_answer;
    @(posedge clk) disable iff (!rst_n)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("access phase was not answered after one wait cycle");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_n)
    ev_vec == '0 |=> (stat_q & ~$past(stat_q)) == '0;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // RULE1
    else $error("a pending bit was set without an event");

  property p_miss_ignored;
    @(posedge clk) disable iff (!rst_n)
    done && !hit |=> $stable(en_q) && ($past(stat_q) & ~stat_q) == '0;
  endproperty
  a_miss_ignored: assert property (p_miss_ignored) // RULE12
    else $error("unmapped access changed the register");

  property p_miss_error;
    @(posedge clk) disable iff (!rst_n)
    first_access && !hit |=> pslverr_q && prdata_q == '0;
  endproperty
  a_miss_error: assert property (p_miss_error)
    else $error("unmapped access was not refused");

endmodule : phy_irq_status_enable

// [verification/tb_phy_irq_status_enable.sv]
// self-checking bench of the phy interrupt status and enable register
// assumes an apb slave that answers with pready, one clock, async reset
`timescale 1ns/1ps
module tb_phy_irq_status_enable;
  typedef struct packed {
    logic [31:0] data;
    logic err;
  } note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [phy_irq_pkg::ADDR_W-1:0] paddr = '0;
  logic [phy_irq_pkg::DATA_W-1:0] pwdata = '0;
  logic [phy_irq_pkg::DATA_W/8-1:0] pstrb = '0;
  logic [phy_irq_pkg::DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  phy_irq_pkg::phy_level_t phy_level = '0;
  logic an_complete = 1'b0;
  logic [7:0] fc_cnt = '0;
  logic [7:0] rx_cnt = '0;
  logic irq;
  note_t notes[$];
  note_t n;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] lfsr = 32'h4643;
  logic [7:0] en_exp = '0;

  always #2 clk = ~clk;

  phy_irq_status_enable #(.CNT_W(8)) dut (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .phy_level(phy_level),
    .an_complete(an_complete),
    .false_carrier_event_counter(fc_cnt),
    .receive_error_event_counter(rx_cnt),
    .irq(irq)
  );

  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s exp %b got %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic apb(logic is_wr, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s, logic [31:0] exp, logic err);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    notes.push_back({exp, err});
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
    apb(1'b1, a, d, s, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] exp, logic err);
    apb(1'b0, a, 32'h0, 4'h0, exp, err);
  endtask : rd

  task automatic cyc(int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  // result watcher: oldest note against each completed transfer
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      n = notes.pop_front();
      cmp_word("prdata", n.data, prdata);
      cmp_bit("pslverr", n.err, pslverr);
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h000, 32'h0, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      lfsr = lfsr_next(lfsr);
      en_exp = (i == 3) ? 8'hff : (i == 4) ? 8'h00 : lfsr[7:0];
      wr(12'h000, {lfsr[31:8], en_exp}, 4'b0001);
      rd(12'h000, {24'h0, en_exp}, 1'b0);
    end
    for (int i = 0; i < 5; i++)
    begin
      phy_level <= phy_irq_pkg::phy_level_t'(phy_level ^ (5'h1 << i));
      cyc(3);
      rd(12'h000, {16'h0, 8'(8'h08 << i), en_exp}, 1'b0);
      rd(12'h000, {24'h0, en_exp}, 1'b0);
    end
    fc_cnt <= 8'h80;
    rx_cnt <= 8'h80;
    cyc(3);
    rd(12'h000, {24'h0, en_exp}, 1'b0);
    fc_cnt <= 8'h81;
    cyc(3);
    rd(12'h000, {16'h0, 8'h02, en_exp}, 1'b0);
    rd(12'h000, {24'h0, en_exp}, 1'b0);
    rx_cnt <= 8'hff;
    cyc(3);
    rd(12'h000, {16'h0, 8'h01, en_exp}, 1'b0);
    en_exp = 8'h04;
    wr(12'h000, 32'h4, 4'b0001);
    an_complete <= 1'b1;
    cyc(3);
    cmp_bit("irq", 1'b1, irq);
    wr(12'h000, 32'h400, 4'b0010);
    cyc(2);
    cmp_bit("irq", 1'b0, irq);
    rd(12'h000, {24'h0, en_exp}, 1'b0);
    an_complete <= 1'b0;
    en_exp = 8'hfb;
    wr(12'h000, 32'hfb, 4'b0001);
    an_complete <= 1'b1;
    cyc(3);
    cmp_bit("irq", 1'b0, irq);
    rd(12'h004, 32'h0, 1'b1);
    apb(1'b1, 12'h008, 32'h0000ffff, 4'b0011, 32'h0, 1'b1);
    rd(12'h000, {16'h0, 8'h04, en_exp}, 1'b0);
    report_and_stop();
  end
endmodule : tb_phy_irq_status_enable
